/* File: rtl/sgoc_pkg.sv */
// shared constants for the switchgear object control block
// assumes a single 200 MHz clock and an axi4-lite register bus
`default_nettype none
package sgoc_pkg;
	// clock rate and documented times
	localparam int unsigned     CLK_KHZ       = 200000;
	localparam int unsigned     PULSE_MAX_MS  = 200;   // max command pulse, 0.2 s
	localparam int unsigned     CTRL_TOUT_MS  = 10000; // control termination, 10 s
	localparam longint unsigned PULSE_MAX_CYC = longint'(PULSE_MAX_MS) * CLK_KHZ;
	localparam longint unsigned CTRL_TOUT_CYC = longint'(CTRL_TOUT_MS) * CLK_KHZ;
	// register byte offsets
	localparam int unsigned ADDR_W         = 8;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_CMD        = 8'h04;
	localparam logic [7:0]  OFS_STAT       = 8'h08;
	localparam logic [7:0]  OFS_SRC        = 8'h0C;
	localparam logic [7:0]  OFS_OPEN_OK    = 8'h10;
	localparam logic [7:0]  OFS_CLOSE_OK   = 8'h14;
	localparam logic [7:0]  OFS_OPEN_FAIL  = 8'h18;
	localparam logic [7:0]  OFS_CLOSE_FAIL = 8'h1C;
	// control register fields
	localparam int unsigned CTRL_TYPE_LSB = 0;
	localparam int unsigned CTRL_SYNC_BIT = 2;
	localparam int unsigned CTRL_RDY_LSB  = 3;
	localparam int unsigned CTRL_CLR_BIT  = 8;
	localparam int unsigned CMD_OPEN_BIT  = 0;
	localparam int unsigned CMD_CLOSE_BIT = 1;
	// status register fields
	localparam int unsigned STAT_POS_LSB  = 0;
	localparam int unsigned STAT_CART_LSB = 4;
	localparam int unsigned STAT_OPEN_CMD = 8;
	localparam int unsigned STAT_CLS_CMD  = 9;
	localparam int unsigned STAT_BUSY     = 10;
	localparam int unsigned STAT_READY    = 11;
	localparam int unsigned STAT_SYNC     = 12;
	// object types, in selector order
	typedef enum logic [1:0] {
		OBJ_WITHDRAWABLE,
		OBJ_BREAKER,
		OBJ_MOTOR_DISCONNECTOR_TYPE,
		OBJ_EARTH_SWITCH
	} sgoc_type_e;
	localparam sgoc_type_e TYPE_RST = OBJ_BREAKER;
	// readiness selector codes
	localparam logic [1:0] RDY_HIGH = 2'h0;
	localparam logic [1:0] RDY_LOW  = 2'h1;
	localparam logic [1:0] RDY_OFF  = 2'h2;
	// position codes, shared by breaker and cart
	localparam logic [2:0] POS_MID    = 3'h0;
	localparam logic [2:0] POS_FIRST  = 3'h1; // open, or cart out
	localparam logic [2:0] POS_SECOND = 3'h2; // closed, or cart in
	localparam logic [2:0] POS_BAD    = 3'h3;
	localparam logic [2:0] POS_UNUSED = 3'h4;
	// status input indices
	localparam int unsigned IN_OPEN     = 0;
	localparam int unsigned IN_CLOSE    = 1;
	localparam int unsigned IN_CART_IN  = 2;
	localparam int unsigned IN_CART_OUT = 3;
	localparam int unsigned IN_READY    = 4;
	localparam int unsigned IN_SYNC     = 5;
	localparam int unsigned N_IN        = 6;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// two contacts into one position code
	function automatic logic [2:0] pos_decode(input logic first_on, input logic second_on);
		case ({second_on, first_on})
			2'b01:   pos_decode = POS_FIRST;
			2'b10:   pos_decode = POS_SECOND;
			2'b11:   pos_decode = POS_BAD;
			default: pos_decode = POS_MID;
		endcase
	endfunction : pos_decode
endpackage : sgoc_pkg
`default_nettype wire

/* File: rtl/sgoc_sync.sv */
// three-stage synchroniser for asynchronous status pins
// assumes pins are slow contacts; a change passes once stages two and three agree
`default_nettype none
module sgoc_sync #(
	parameter int unsigned WIDTH = 6
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// raw pins and filtered result
	input  wire logic [WIDTH-1:0] pin,
	output var  logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_ff; // first stage, read by s2 only
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;

	// shift chain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// accept a bit only where the late stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					level[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule : sgoc_sync
`default_nettype wire

/* File: rtl/sgoc_cnt.sv */
// request statistics counter with synchronous clear
// assumes one increment pulse per event; holds at full scale instead of wrapping
`default_nettype none
module sgoc_cnt #(
	parameter int unsigned WIDTH = 32
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// control
	input  wire logic             clr,
	input  wire logic             inc,
	// value
	output var  logic [WIDTH-1:0] count
);
	// clear wins: a clear has to leave every counter at zero together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else if (clr) begin
			count <= '0;
		end else if (inc && (count != '1)) begin
			count <= count + 1'b1;
		end
	end
endmodule : sgoc_cnt
`default_nettype wire

/* File: rtl/sgoc_top.sv */
// object control and monitoring for one switchgear object
// assumes an axi4-lite master, contact pins asynchronous, goose levels on aclk
//
// Overview of operation
// - synchrocheck in use blocks close without permission
// - readiness selector: high, low, or not checked
// - count successful open and close requests
// - count failed open and close requests
// - clear bit zeroes counters, returns to zero
// - withdrawable breaker: cart, breaker, checks, control
// - fixed breaker: position, control, checks, no cart
// - motor disconnector: position and control, no checks
// - earth switch: position only, no commands
// - open and close pulses on two relays
// - each status input from pin or goose
// - breaker position intermediate, open, closed, bad
// - cart position codes, four when unused
// - pulse ends at maximum or on status change
// - no change by timeout ends control, error
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
module sgoc_top #(
	parameter int unsigned PULSE_CYC = 32'(sgoc_pkg::PULSE_MAX_CYC),
	parameter int unsigned TOUT_CYC  = 32'(sgoc_pkg::CTRL_TOUT_CYC),
	parameter int unsigned CNT_W     = 32
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output var  logic        awready,
	// axi4-lite write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output var  logic        wready,
	// axi4-lite write response
	output var  logic [1:0]  bresp,
	output var  logic        bvalid,
	input  wire logic        bready,
	// axi4-lite read address
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output var  logic        arready,
	// axi4-lite read data
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	output var  logic        rvalid,
	input  wire logic        rready,
	// status contacts from digital input pins
	input  wire logic        open_status_input,
	input  wire logic        close_status_input,
	input  wire logic        cart_inserted_input,
	input  wire logic        cart_withdrawn_input,
	input  wire logic        ready_status_input,
	input  wire logic        sync_permit_input,
	// same statuses received by goose, on aclk
	input  wire logic [5:0]  goose_status,
	// output relays and error event
	output var  logic        first_output_relay,
	output var  logic        second_output_relay,
	output var  logic        control_error
);
	typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CLOSE} sgoc_state_e;

	// configuration registers
	sgoc_pkg::sgoc_type_e obj_type_ff;   // object type selector
	logic                 sync_use_ff;   // synchrocheck in use
	logic [1:0]           rdy_sel_ff;    // readiness selector
	logic                 clr_ff;        // clear statistics, self returning
	logic [5:0]           src_sel_ff;    // per input: 1 takes goose
	logic                 open_req_ff;   // request pulses from command writes
	logic                 close_req_ff;
	// axi bookkeeping
	logic                 aw_held_ff;
	logic                 w_held_ff;
	logic [7:0]           awaddr_ff;
	logic [31:0]          wdata_ff;
	logic [3:0]           wstrb_ff;
	logic                 do_write;
	// status path
	logic [5:0]           pin_level;     // synchronised pins
	logic [5:0]           sts;           // selected sources
	logic [2:0]           brk_pos;
	logic [2:0]           cart_pos;
	logic                 sync_ok;
	logic                 ready_ok;
	logic                 is_breaker;
	// control sequencer
	sgoc_state_e          state_ff;
	sgoc_state_e          nxt_state;
	logic [31:0]          timer_ff;
	logic                 reached;       // target position seen
	logic                 timed_out;
	logic                 open_ok_inc;
	logic                 close_ok_inc;
	logic                 open_fail_inc;
	logic                 close_fail_inc;
	logic                 nxt_error;
	// statistics
	logic [CNT_W-1:0]     open_ok_cnt;
	logic [CNT_W-1:0]     close_ok_cnt;
	logic [CNT_W-1:0]     open_fail_cnt;
	logic [CNT_W-1:0]     close_fail_cnt;

	// merge write strobes into an old word
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		strb_merge = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				strb_merge[8*b +: 8] = new_v[8*b +: 8];
			end
		end
	endfunction : strb_merge

	// address in map, aligned, within the eight words
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a[1:0] == 2'h0) && (a <= sgoc_pkg::OFS_CLOSE_FAIL);
	endfunction : addr_hit

	// ---------------- status inputs ----------------
	sgoc_sync #(
		.WIDTH (sgoc_pkg::N_IN)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     ({sync_permit_input, ready_status_input, cart_withdrawn_input,
		           cart_inserted_input, close_status_input, open_status_input}),
		.level   (pin_level)
	);

	// source select per input, goose needs no synchroniser
	always_comb begin
		for (int i = 0; i < sgoc_pkg::N_IN; i++) begin
			sts[i] = src_sel_ff[i] ? goose_status[i] : pin_level[i];
		end
	end

	// position decode relies on the contacts meaning what they say
	always_comb begin
		brk_pos = sgoc_pkg::pos_decode(sts[sgoc_pkg::IN_OPEN],
			sts[sgoc_pkg::IN_CLOSE]);
		if (obj_type_ff == sgoc_pkg::OBJ_WITHDRAWABLE) begin
			cart_pos = sgoc_pkg::pos_decode(sts[sgoc_pkg::IN_CART_OUT],
				sts[sgoc_pkg::IN_CART_IN]);
		end else begin
			cart_pos = sgoc_pkg::POS_UNUSED;
		end
	end

	// close gates, only breaker types check them
	always_comb begin
		is_breaker = (obj_type_ff == sgoc_pkg::OBJ_WITHDRAWABLE) ||
			(obj_type_ff == sgoc_pkg::OBJ_BREAKER);
		sync_ok = !sync_use_ff || sts[sgoc_pkg::IN_SYNC];
		case (rdy_sel_ff)
			sgoc_pkg::RDY_HIGH: ready_ok = sts[sgoc_pkg::IN_READY];
			sgoc_pkg::RDY_LOW:  ready_ok = !sts[sgoc_pkg::IN_READY];
			default:            ready_ok = 1'b1;
		endcase
	end

	// ---------------- control sequencer ----------------
	// target reached ends the pulse early; status is checked every cycle
	always_comb begin
		reached = (state_ff == ST_OPEN) ? (brk_pos == sgoc_pkg::POS_FIRST) :
			(brk_pos == sgoc_pkg::POS_SECOND);
		timed_out = (timer_ff >= TOUT_CYC - 1);
	end

	// next state and statistics events
	always_comb begin
		nxt_state      = state_ff;
		open_ok_inc    = 1'b0;
		close_ok_inc   = 1'b0;
		open_fail_inc  = 1'b0;
		close_fail_inc = 1'b0;
		nxt_error      = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				// open takes priority over a simultaneous close
				if (open_req_ff) begin
					if (obj_type_ff == sgoc_pkg::OBJ_EARTH_SWITCH) begin
						open_fail_inc = 1'b1;
					end else begin
						nxt_state = ST_OPEN;
					end
				end else if (close_req_ff) begin
					if (obj_type_ff == sgoc_pkg::OBJ_EARTH_SWITCH) begin
						close_fail_inc = 1'b1;
					end else if (is_breaker && !(sync_ok && ready_ok)) begin
						close_fail_inc = 1'b1;
					end else begin
						nxt_state = ST_CLOSE;
					end
				end
			end
			ST_OPEN, ST_CLOSE: begin
				if (reached) begin
					nxt_state    = ST_IDLE;
					open_ok_inc  = (state_ff == ST_OPEN);
					close_ok_inc = (state_ff == ST_CLOSE);
				end else if (timed_out) begin
					nxt_state      = ST_IDLE;
					nxt_error      = 1'b1;
					open_fail_inc  = (state_ff == ST_OPEN);
					close_fail_inc = (state_ff == ST_CLOSE);
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state register and error event pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff      <= ST_IDLE;
			control_error <= 1'b0;
		end else begin
			state_ff      <= nxt_state;
			control_error <= nxt_error;
		end
	end

	// elapsed time since the command started
	always_ff @(posedge aclk) begin
		if (!aresetn || state_ff == ST_IDLE) begin
			timer_ff <= '0;
		end else begin
			timer_ff <= timer_ff + 32'h0000_0001;
		end
	end

	// relays: on at entry, off at max length or on status change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_output_relay  <= 1'b0;
			second_output_relay <= 1'b0;
		end else begin
			first_output_relay  <= (nxt_state == ST_OPEN) &&
				!(state_ff == ST_OPEN && timer_ff >= PULSE_CYC - 1);
			second_output_relay <= (nxt_state == ST_CLOSE) &&
				!(state_ff == ST_CLOSE && timer_ff >= PULSE_CYC - 1);
		end
	end

	// ---------------- statistics ----------------
	sgoc_cnt #(.WIDTH(CNT_W)) u_open_ok (
		.aclk (aclk), .aresetn (aresetn), .clr (clr_ff),
		.inc  (open_ok_inc), .count (open_ok_cnt)
	);
	sgoc_cnt #(.WIDTH(CNT_W)) u_close_ok (
		.aclk (aclk), .aresetn (aresetn), .clr (clr_ff),
		.inc  (close_ok_inc), .count (close_ok_cnt)
	);
	sgoc_cnt #(.WIDTH(CNT_W)) u_open_fail (
		.aclk (aclk), .aresetn (aresetn), .clr (clr_ff),
		.inc  (open_fail_inc), .count (open_fail_cnt)
	);
	sgoc_cnt #(.WIDTH(CNT_W)) u_close_fail (
		.aclk (aclk), .aresetn (aresetn), .clr (clr_ff),
		.inc  (close_fail_inc), .count (close_fail_cnt)
	);

	// ---------------- axi4-lite write side ----------------
	assign awready  = !aw_held_ff && !bvalid;
	assign wready   = !w_held_ff && !bvalid;
	assign do_write = aw_held_ff && w_held_ff && !bvalid;

	// hold address and data until both have arrived, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= awaddr;
			end else if (do_write) begin
				aw_held_ff <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= wdata;
				wstrb_ff  <= wstrb;
			end else if (do_write) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// write response, unmapped addresses answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= sgoc_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= addr_hit(awaddr_ff) ? sgoc_pkg::RESP_OKAY : sgoc_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// configuration writes; counters and status are read only
	always_ff @(posedge aclk) begin
		logic [31:0] m;
		m = 32'h0000_0000;
		if (!aresetn) begin
			obj_type_ff <= sgoc_pkg::TYPE_RST;
			sync_use_ff <= 1'b0;
			rdy_sel_ff  <= sgoc_pkg::RDY_OFF;
			src_sel_ff  <= 6'h00;
		end else if (do_write && awaddr_ff == sgoc_pkg::OFS_CTRL) begin
			m = strb_merge({23'h0, clr_ff, 3'h0, rdy_sel_ff, sync_use_ff, obj_type_ff},
				wdata_ff, wstrb_ff);
			obj_type_ff <= sgoc_pkg::sgoc_type_e'(m[sgoc_pkg::CTRL_TYPE_LSB +: 2]);
			sync_use_ff <= m[sgoc_pkg::CTRL_SYNC_BIT];
			rdy_sel_ff  <= m[sgoc_pkg::CTRL_RDY_LSB +: 2];
		end else if (do_write && awaddr_ff == sgoc_pkg::OFS_SRC) begin
			m = strb_merge({26'h0, src_sel_ff}, wdata_ff, wstrb_ff);
			src_sel_ff <= m[5:0];
		end
	end

	// one-cycle clear and request pulses from writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clr_ff       <= 1'b0;
			open_req_ff  <= 1'b0;
			close_req_ff <= 1'b0;
		end else begin
			clr_ff <= do_write && awaddr_ff == sgoc_pkg::OFS_CTRL && wstrb_ff[1] &&
				wdata_ff[sgoc_pkg::CTRL_CLR_BIT];
			open_req_ff  <= do_write && awaddr_ff == sgoc_pkg::OFS_CMD && wstrb_ff[0] &&
				wdata_ff[sgoc_pkg::CMD_OPEN_BIT];
			close_req_ff <= do_write && awaddr_ff == sgoc_pkg::OFS_CMD && wstrb_ff[0] &&
				wdata_ff[sgoc_pkg::CMD_CLOSE_BIT];
		end
	end

	// ---------------- axi4-lite read side ----------------
	assign arready = !rvalid;

	// registered read data, one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= sgoc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= addr_hit(araddr) ? sgoc_pkg::RESP_OKAY : sgoc_pkg::RESP_SLVERR;
			case (araddr)
				sgoc_pkg::OFS_CTRL:
					rdata <= {23'h0, clr_ff, 3'h0, rdy_sel_ff, sync_use_ff, obj_type_ff};
				sgoc_pkg::OFS_STAT:
					rdata <= {19'h0, sts[sgoc_pkg::IN_SYNC], sts[sgoc_pkg::IN_READY],
						(state_ff != ST_IDLE), second_output_relay, first_output_relay,
						1'b0, cart_pos, 1'b0, brk_pos};
				sgoc_pkg::OFS_SRC:        rdata <= {26'h0, src_sel_ff};
				sgoc_pkg::OFS_OPEN_OK:    rdata <= 32'(open_ok_cnt);
				sgoc_pkg::OFS_CLOSE_OK:   rdata <= 32'(close_ok_cnt);
				sgoc_pkg::OFS_OPEN_FAIL:  rdata <= 32'(open_fail_cnt);
				sgoc_pkg::OFS_CLOSE_FAIL: rdata <= 32'(close_fail_cnt);
				default:                  rdata <= 32'h0000_0000;
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------- assertions ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence close_refused_s;
		state_ff == ST_IDLE && !open_req_ff && close_req_ff && is_breaker;
	endsequence

	a_sync_blocks_close: assert property (
		close_refused_s and (sync_use_ff && !sts[sgoc_pkg::IN_SYNC])
		|=> !second_output_relay && state_ff == ST_IDLE)
		else $error("close issued without sync permission");
	a_ready_blocks_close: assert property (
		close_refused_s and (rdy_sel_ff == sgoc_pkg::RDY_LOW && sts[sgoc_pkg::IN_READY])
		|=> !second_output_relay ##1 (close_fail_cnt != '0 || $past(clr_ff)))
		else $error("close issued against readiness selector");
	a_open_success_count: assert property (
		state_ff == ST_OPEN && reached && !clr_ff && open_ok_cnt != '1
		|=> open_ok_cnt == CNT_W'($past(open_ok_cnt) + 1'b1))
		else $error("successful open not counted");
	a_clear_all_zero: assert property (
		clr_ff |=> !clr_ff && open_ok_cnt == '0 && close_ok_cnt == '0 &&
		open_fail_cnt == '0 && close_fail_cnt == '0)
		else $error("clear statistics incomplete");
	a_earth_no_command: assert property (
		state_ff == ST_IDLE && obj_type_ff == sgoc_pkg::OBJ_EARTH_SWITCH
		|=> !first_output_relay && !second_output_relay)
		else $error("earth switch received a command");
	a_cart_not_used: assert property (
		obj_type_ff != sgoc_pkg::OBJ_WITHDRAWABLE |-> cart_pos == sgoc_pkg::POS_UNUSED)
		else $error("cart position shown for fixed object");
	a_pulse_max_len: assert property (
		first_output_relay |-> state_ff == ST_OPEN && timer_ff < PULSE_CYC)
		else $error("open pulse beyond maximum length");
	a_timeout_error: assert property (
		state_ff != ST_IDLE && timed_out && !reached
		|=> control_error && state_ff == ST_IDLE ##1 !control_error)
		else $error("timeout did not end control with one error pulse");
	a_bresp_held: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before ready");
endmodule : sgoc_top
`default_nettype wire

/* File: tb/sgoc_gear_model.sv */
// far-side model: breaker contacts, cart contacts, spring and sync
// assumes relays on aclk; the breaker travels a few cycles after a pulse
`default_nettype none
module sgoc_gear_model (
	// clock
	input  wire logic aclk,
	// relays and test knobs
	input  wire logic open_cmd,
	input  wire logic close_cmd,
	input  wire logic stuck,
	input  wire logic sync_ok,
	// status contacts
	output var  logic open_st,
	output var  logic close_st,
	output var  logic cart_in,
	output var  logic cart_out,
	output var  logic ready,
	output var  logic sync_st
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       closed = 1'b0; // starts open
	logic [2:0] trav   = 3'h0; // nonzero while moving
	// travel only while the matching relay pulls; stuck models a jammed drive
	always @(posedge aclk) begin
		if (!stuck && ((close_cmd && !closed) || (open_cmd && closed))) begin
			// travel completes on the fifth pulled edge
			if (trav == 3'h4) begin
				closed <= !closed;
				trav   <= 3'h0;
			end else begin
				trav <= trav + 3'h1;
			end
		end else begin
			trav <= 3'h0;
		end
	end
	// both contacts drop in mid travel
	assign open_st  = !closed && trav == 3'h0;
	assign close_st = closed && trav == 3'h0;
	assign cart_in  = 1'b1;
	assign cart_out = 1'b0;
	assign ready    = 1'b1;
	assign sync_st  = sync_ok;
endmodule : sgoc_gear_model
`default_nettype wire

/* File: tb/sgoc_top_tb_top.sv */
// bench for the object control block: axi4-lite tasks plus gear model
// assumes short pulse and timeout parameters to keep the run brief
`default_nettype none
module switchgear_object_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0]  wstrb = 4'hF; // byte lanes, narrowed to test the clear lane
	logic [5:0]  goose = 6'h00; // goose statuses, used once sources are switched
	int relay_cyc = 0, base = 0; // open relay high cycles, and a mark
	logic [1:0]  bresp, rresp;
	logic stuck = 1'b0, sync_ok = 1'b0, o_st, c_st, ci, co, rdy, sy, rl1, rl2, cerr;
	int error_cnt = 0, tests_run = 0, err_pulses = 0;
	// clock, 200 MHz
	initial forever #2.5 aclk = ~aclk;
	// error pulses are one cycle wide, so count them every edge
	always @(posedge aclk) if (cerr === 1'b1) err_pulses++;
	// open relay length is measured in sampled edges
	always @(posedge aclk) if (rl1 === 1'b1) relay_cyc++;
	sgoc_top #(.PULSE_CYC(20), .TOUT_CYC(60)) DUT (.aclk, .aresetn, .awaddr,
		.awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .open_status_input(o_st),
		.close_status_input(c_st), .cart_inserted_input(ci), .cart_withdrawn_input(co),
		.ready_status_input(rdy), .sync_permit_input(sy), .goose_status(goose),
		.first_output_relay(rl1), .second_output_relay(rl2), .control_error(cerr));
	sgoc_gear_model gear (.aclk, .open_cmd(rl1), .close_cmd(rl2), .stuck, .sync_ok,
		.open_st(o_st), .close_st(c_st), .cart_in(ci), .cart_out(co), .ready(rdy),
		.sync_st(sy));
	// verdict and end of run
	task automatic finish_test();
		$display("errors %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// a hung handshake counts as a mismatch and ends the run
	task automatic hang();
		error_cnt++;
		finish_test();
	endtask : hang
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		if (i == 50) hang();
		@(posedge aclk); // an edge passes before the next request
	endtask : wr
	// read: address held until taken, data taken on the rvalid edge
	task automatic rd(input logic [7:0] a);
		int i;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		rready <= 1'b0;
		if (i == 50) hang();
		@(posedge aclk); // an edge passes before the next request
	endtask : rd
	// command, wait for the sequencer to go idle, then check one counter
	task automatic cmd(input logic [31:0] c, input logic [7:0] a, input logic [31:0] e);
		int i;
		wr(8'h04, c);
		repeat (3) @(posedge aclk);
		for (i = 0; i < 100; i++) begin
			rd(8'h08);
			if (d[10] === 1'b0) break;
		end
		if (i == 100) hang();
		rd(a);
		chk("counter", e, d);
	endtask : cmd
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(8'h00); chk("ctrl reset", 32'h00000011, d);
		rd(8'h08); chk("stat reset", 32'h00000841, d);
		cmd(32'h2, 8'h14, 32'h1);
		cmd(32'h1, 8'h10, 32'h1);
		wr(8'h00, 32'h15);
		cmd(32'h2, 8'h1C, 32'h1);
		sync_ok <= 1'b1;
		repeat (4) @(posedge aclk); // permission pin needs the synchroniser delay
		cmd(32'h2, 8'h14, 32'h2);
		wr(8'h00, 32'h09);
		cmd(32'h1, 8'h10, 32'h2);
		cmd(32'h2, 8'h1C, 32'h2);
		wr(8'h00, 32'h01);
		cmd(32'h2, 8'h14, 32'h3);
		sync_ok <= 1'b0;
		wr(8'h00, 32'h0E);
		cmd(32'h1, 8'h10, 32'h3);
		cmd(32'h2, 8'h14, 32'h4);
		wr(8'h00, 32'h13);
		cmd(32'h2, 8'h1C, 32'h3);
		wr(8'h00, 32'h10);
		rd(8'h08); chk("cart pos", 32'h2, {29'h0, d[6:4]});
		goose <= 6'h03;
		wr(8'h0C, 32'h03);
		rd(8'h08); chk("goose pos", 32'h3, {29'h0, d[2:0]});
		wr(8'h0C, 32'h00);
		stuck <= 1'b1;
		base = relay_cyc;
		cmd(32'h1, 8'h18, 32'h1);
		chk("open pulse", 32'h14, relay_cyc - base);
		chk("error pulses", 32'h1, err_pulses);
		wstrb <= 4'h1;
		wr(8'h00, 32'h110);
		wstrb <= 4'hF;
		rd(8'h18); chk("no clear lane", 32'h1, d);
		wr(8'h00, 32'h110);
		rd(8'h10); chk("open ok clr", 32'h0, d);
		rd(8'h1C); chk("close fail clr", 32'h0, d);
		rd(8'h00); chk("clear bit", 32'h10, d);
		rd(8'h20); chk("unmapped", {30'h0, 2'h2}, {30'h0, rresp});
		finish_test();
	end
endmodule : switchgear_object_control_tb_top
`default_nettype wire
